// ===== rtl/tcmd_top.sv
`timescale 1ns/10ps
// Function
// - address bit 13 selects memory or registers
// - channel range checked against stream rate, reported in addr_ok only
// - mode bit zero means normal switching
// - bit 15 enables law conversion when switching
// - bit 14 selects constant or variable delay
// - bits 13-9 give source stream
// - bits 8-1 give source channel
// - mode bit one means special channel mode
// - control field picks tristate, message, test
// - message conversion follows bit 15
// - message mode sends bits 10-3
// - control field governs bidirectional output value
// - differing laws translate, equal laws pass
module tcmd_top (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // host parallel port
  input wire logic [13:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_cs,
  input wire logic i_we,
  input wire logic i_high_sel, // selects high word for memory access
  output logic [15:0] o_rdata,
  output logic o_ack,
  // channel lookup from the output timing side
  input wire logic [12:0] i_out_index,
  input wire logic [7:0] i_switched_byte,
  input wire logic [7:0] i_bert_byte,
  output tcmd_pkg::tcmd_decode_t o_dec,
  output logic [7:0] o_stream_data,
  output logic o_stream_oe,
  output logic o_var_fault
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] low_mem [tcmd_pkg::ENTRIES]; // low connection words
  logic [1:0] high_mem [tcmd_pkg::ENTRIES]; // coding laws per channel
  logic [15:0] low_next; // value to store on a low write
  logic low_we;
  logic high_we;
  tcmd_pkg::tcmd_rate_t rate_reg;
  tcmd_pkg::tcmd_rate_t rate_next;
  logic var_en_reg; // variable delay global enable
  logic var_en_next;
  logic var_fault_reg; // variable delay used while disabled
  logic var_fault_next;
  logic rsv_fault_reg; // reserved bits written non-zero
  logic rsv_fault_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  tcmd_pkg::tcmd_state_t state_reg;
  tcmd_pkg::tcmd_state_t state_next;
  tcmd_pkg::tcmd_decode_t dec_reg;
  tcmd_pkg::tcmd_decode_t dec_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic oe_reg;
  logic oe_next;
  tcmd_pkg::tcmd_decode_t dec_now; // decode of addressed entry
  tcmd_pkg::tcmd_decode_t dec_wr; // decode of incoming write
  tcmd_pkg::tcmd_law_t law_now;
  logic [7:0] pre_byte;
  logic [7:0] xl_byte;
  logic mem_access;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign mem_access = i_addr[tcmd_pkg::MEM_SEL_BIT];

  // ----------------------------------------
  // host access state machine
  // ----------------------------------------
  // one access takes two cycles; ack pulses two cycles after the strobe is sampled in idle
  always_comb
  begin
    state_next = tcmd_pkg::ST_IDLE;
    rate_next = rate_reg;
    var_en_next = var_en_reg;
    rsv_fault_next = rsv_fault_reg;
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    low_we = 1'b0;
    high_we = 1'b0;
    low_next = i_wdata;
    case (state_reg)
      tcmd_pkg::ST_IDLE:
      begin
        if (i_cs)
          state_next = i_we ? tcmd_pkg::ST_WRITE : tcmd_pkg::ST_READ;
      end
      tcmd_pkg::ST_WRITE:
      begin
        ack_next = 1'b1;
        if (mem_access)
        begin
          low_we = !i_high_sel;
          high_we = i_high_sel;
          // a bad reserved field is flagged, not rejected
          if (!i_high_sel && dec_wr.special && !dec_wr.rsv_ok)
            rsv_fault_next = 1'b1;
        end
        else
        begin
          // local registers
          case (i_addr[12:0])
            tcmd_pkg::REG_STREAM_RATE: rate_next = tcmd_pkg::tcmd_rate_t'(i_wdata[1:0]);
            tcmd_pkg::REG_CONTROL: var_en_next = i_wdata[tcmd_pkg::CTRL_VAR_EN];
            tcmd_pkg::REG_STATUS: rsv_fault_next = 1'b0; // write clears
            default: ; // unmapped write ignored
          endcase
        end
      end
      tcmd_pkg::ST_READ:
      begin
        ack_next = 1'b1;
        if (mem_access)
          rdata_next = i_high_sel ? {14'h0000, high_mem[i_addr[12:0]]} : low_mem[i_addr[12:0]];
        else
        begin
          case (i_addr[12:0])
            tcmd_pkg::REG_STREAM_RATE: rdata_next = {14'h0000, rate_reg};
            tcmd_pkg::REG_CONTROL: rdata_next = {15'h0000, var_en_reg};
            tcmd_pkg::REG_STATUS: rdata_next = {14'h0000, var_fault_reg, rsv_fault_reg};
            default: rdata_next = 16'h0000;
          endcase
        end
      end
      default: state_next = tcmd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state_reg <= tcmd_pkg::ST_IDLE;
      rate_reg <= tcmd_pkg::RATE_2M;
      var_en_reg <= 1'b0;
      rsv_fault_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      ack_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      rate_reg <= rate_next;
      var_en_reg <= var_en_next;
      rsv_fault_reg <= rsv_fault_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  // memory writes; storage has no reset, like a real connection ram
  always_ff @(posedge i_clock)
  begin
    if (low_we)
      low_mem[i_addr[12:0]] <= low_next;
    if (high_we)
      high_mem[i_addr[12:0]] <= i_wdata[1:0];
  end

  // ----------------------------------------
  // word decoders
  // ----------------------------------------
  tcmd_word_decode u_dec_now (
    .i_word(low_mem[i_out_index]),
    .i_src_rate(rate_reg),
    .o_dec(dec_now)
  );

  tcmd_word_decode u_dec_wr (
    .i_word(i_wdata),
    .i_src_rate(rate_reg),
    .o_dec(dec_wr)
  );

  // ----------------------------------------
  // output channel path
  // ----------------------------------------
  assign law_now = high_mem[i_out_index];
  // message byte replaces switched data in message mode
  assign pre_byte = dec_now.use_msg ? dec_now.message : i_switched_byte;

  tcmd_law_xlate u_xlate (
    .i_conv_en(dec_now.conv_en),
    .i_law(law_now),
    .i_byte(pre_byte),
    .o_byte(xl_byte)
  );

  always_comb
  begin
    dec_next = dec_now;
    data_next = 8'h00;
    oe_next = dec_now.drive_en;
    var_fault_next = var_fault_reg;
    if (dec_now.use_bert)
      data_next = i_bert_byte; // test byte never converted
    else if (dec_now.drive_en)
      data_next = xl_byte;
    // variable delay without the global enable is only reported
    if (dec_now.use_switch && dec_now.var_delay && !var_en_reg)
      var_fault_next = 1'b1;
    if (state_reg == tcmd_pkg::ST_WRITE && !mem_access && i_addr[12:0] == tcmd_pkg::REG_STATUS)
      var_fault_next = (dec_now.use_switch && dec_now.var_delay && !var_en_reg); // set wins
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      dec_reg <= '0;
      data_reg <= 8'h00;
      oe_reg <= 1'b0;
      var_fault_reg <= 1'b0;
    end
    else
    begin
      dec_reg <= dec_next;
      data_reg <= data_next;
      oe_reg <= oe_next;
      var_fault_reg <= var_fault_next;
    end
  end

  assign o_dec = dec_reg;
  assign o_stream_data = data_reg;
  assign o_stream_oe = oe_reg;
  assign o_var_fault = var_fault_reg;
  assign o_rdata = rdata_reg;
  assign o_ack = ack_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_tristate_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    (dec_now.special && dec_now.per_channel_control == tcmd_pkg::PCC_TRISTATE) |=> !o_stream_oe)
    else $error("tristate channel drove the stream");
  chk_message_byte: assert property (@(posedge i_clock) disable iff (i_rst)
    (dec_now.use_msg && !dec_now.conv_en) |=> o_stream_data == $past(dec_now.message))
    else $error("message byte not sent");
  chk_normal_fields: assert property (@(posedge i_clock) disable iff (i_rst)
    !low_mem[i_out_index][0] |=> (o_dec.src_stream == $past(low_mem[i_out_index][13:9])
    && o_dec.src_channel == $past(low_mem[i_out_index][8:1]) && !o_dec.special))
    else $error("normal fields wrong");
  chk_delay_select: assert property (@(posedge i_clock) disable iff (i_rst)
    !dec_now.special |=> o_dec.var_delay == $past(low_mem[i_out_index][14]))
    else $error("delay select wrong");
  chk_rate_limit: assert property (@(posedge i_clock) disable iff (i_rst)
    (!dec_now.special && rate_reg == tcmd_pkg::RATE_2M && dec_now.src_channel > 8'h1f) |=> !o_dec.addr_ok)
    else $error("channel range not checked");
  chk_equal_law: assert property (@(posedge i_clock) disable iff (i_rst)
    (dec_now.use_switch && law_now.input_law == law_now.output_law) |=> o_stream_data == $past(i_switched_byte))
    else $error("equal laws altered data");
  chk_no_conv: assert property (@(posedge i_clock) disable iff (i_rst)
    (dec_now.use_switch && !dec_now.conv_en) |=> o_stream_data == $past(i_switched_byte))
    else $error("conversion without enable");
  chk_reg_decode: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == tcmd_pkg::ST_WRITE && !mem_access && i_addr[12:0] == tcmd_pkg::REG_CONTROL)
    |=> var_en_reg == $past(i_wdata[0]))
    else $error("register write lost");
  chk_ack_timing: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == tcmd_pkg::ST_IDLE && i_cs) |=> ##1 o_ack)
    else $error("ack late");
  // ack is a single pulse; a stuck ack would let the host run ahead of the port
  chk_ack_single: assert property (@(posedge i_clock) disable iff (i_rst)
    o_ack |=> !o_ack)
    else $error("ack held too long");
  // test byte goes out untouched, never through the law translator
  chk_bert_source: assert property (@(posedge i_clock) disable iff (i_rst)
    dec_now.use_bert |=> o_stream_data == $past(i_bert_byte))
    else $error("test byte not sent");
  // fault stays until the host clears it through the status register
  chk_fault_sticky: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_var_fault && !(state_reg == tcmd_pkg::ST_WRITE && !mem_access && i_addr[12:0] == tcmd_pkg::REG_STATUS))
    |=> o_var_fault)
    else $error("variable delay fault lost");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  // main scenarios: converted message, test output, enabled variable delay,
  // per-channel tristate and a source channel past the rate limit
  cov_message: cover property (@(posedge i_clock) dec_now.use_msg && dec_now.conv_en);
  cov_bert: cover property (@(posedge i_clock) dec_now.use_bert);
  cov_var: cover property (@(posedge i_clock) dec_now.var_delay && var_en_reg);
  cov_tristate: cover property (@(posedge i_clock) dec_now.special && dec_now.per_channel_control == tcmd_pkg::PCC_TRISTATE);
  cov_rate_limit: cover property (@(posedge i_clock) dec_now.use_switch && !dec_now.addr_ok);
endmodule

// ===== rtl/tcmd_pkg.sv
package tcmd_pkg;
  // ----------------------------------------
  // host port address layout
  // ----------------------------------------
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned MEM_SEL_BIT = 13;
  localparam int unsigned STREAM_LSB = 8;
  localparam int unsigned STREAM_W = 5;
  localparam int unsigned CHAN_LSB = 0;
  localparam int unsigned CHAN_W = 8;
  localparam int unsigned ENTRIES = 8192;
  localparam int unsigned IDX_W = 13;
  // local register space (address bit 13 low), word index
  localparam logic [12:0] REG_STREAM_RATE = 13'h0000;
  localparam logic [12:0] REG_CONTROL = 13'h0001;
  localparam logic [12:0] REG_STATUS = 13'h0002;
  // control register fields
  localparam int unsigned CTRL_VAR_EN = 0;
  // ----------------------------------------
  // connection word field positions
  // ----------------------------------------
  localparam int unsigned MODE_BIT = 0;
  localparam int unsigned CONV_BIT = 15;
  localparam int unsigned VAR_BIT = 14;
  localparam int unsigned SS_LSB = 9;
  localparam int unsigned SC_LSB = 1;
  localparam int unsigned PCC_LSB = 1;
  localparam int unsigned MSG_LSB = 3;
  localparam int unsigned RSV_LSB = 11;
  localparam int unsigned RSV_W = 4;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // channel limits per rate: 2.048, 4.096, 8.192, 16.384 Mbps
  localparam logic [7:0] MAX_CH_2M = 8'h1f;
  localparam logic [7:0] MAX_CH_4M = 8'h3f;
  localparam logic [7:0] MAX_CH_8M = 8'h7f;
  localparam logic [7:0] MAX_CH_16M = 8'hff;
  // ----------------------------------------
  // enumerations and carriers
  // ----------------------------------------
  typedef enum logic [1:0] {RATE_2M, RATE_4M, RATE_8M, RATE_16M} tcmd_rate_t;
  typedef enum logic [1:0] {PCC_TRISTATE, PCC_MESSAGE, PCC_BERT, PCC_RESERVED} tcmd_pcc_t;
  typedef enum {ST_IDLE, ST_WRITE, ST_READ} tcmd_state_t;
  typedef struct packed {
    logic special;        // per-channel special mode
    logic conv_en;        // coding-law conversion requested
    logic var_delay;      // variable-delay source
    logic [4:0] src_stream;
    logic [7:0] src_channel;
    tcmd_pcc_t per_channel_control;
    logic [7:0] message;
    logic drive_en;       // channel drives the output stream
    logic use_msg;        // output byte is the message byte
    logic use_bert;       // output byte from the test generator
    logic use_switch;     // output byte from a delay memory
    logic addr_ok;        // channel index in range for rate
    logic rsv_ok;         // reserved bits are zero
  } tcmd_decode_t;
  typedef struct packed {
    logic input_law;
    logic output_law;
  } tcmd_law_t;
endpackage

// ===== rtl/tcmd_word_decode.sv
`timescale 1ns/10ps
// combinational decode of one low connection word
module tcmd_word_decode (
  // connection word and stream rate
  input wire logic [15:0] i_word,
  input wire tcmd_pkg::tcmd_rate_t i_src_rate,
  // decoded fields
  output tcmd_pkg::tcmd_decode_t o_dec
);
  // ----------------------------------------
  // rate limit lookup
  // ----------------------------------------
  function automatic logic [7:0] max_chan(input tcmd_pkg::tcmd_rate_t rate);
    case (rate)
      tcmd_pkg::RATE_2M: max_chan = tcmd_pkg::MAX_CH_2M;
      tcmd_pkg::RATE_4M: max_chan = tcmd_pkg::MAX_CH_4M;
      tcmd_pkg::RATE_8M: max_chan = tcmd_pkg::MAX_CH_8M;
      default: max_chan = tcmd_pkg::MAX_CH_16M;
    endcase
  endfunction

  // ----------------------------------------
  // field split
  // ----------------------------------------
  always_comb
  begin
    o_dec = '0;
    o_dec.special = i_word[tcmd_pkg::MODE_BIT];
    o_dec.conv_en = i_word[tcmd_pkg::CONV_BIT];
    o_dec.rsv_ok = 1'b1;
    o_dec.addr_ok = 1'b1;
    if (!o_dec.special)
    begin
      // normal switched connection
      o_dec.var_delay = i_word[tcmd_pkg::VAR_BIT];
      o_dec.src_stream = i_word[tcmd_pkg::SS_LSB +: 5];
      o_dec.src_channel = i_word[tcmd_pkg::SC_LSB +: 8];
      o_dec.addr_ok = (o_dec.src_channel <= max_chan(i_src_rate));
      o_dec.use_switch = 1'b1;
      o_dec.drive_en = 1'b1;
    end
    else
    begin
      // special per-channel mode replaces switching
      o_dec.per_channel_control = tcmd_pkg::tcmd_pcc_t'(i_word[tcmd_pkg::PCC_LSB +: 2]);
      o_dec.rsv_ok = (i_word[tcmd_pkg::RSV_LSB +: tcmd_pkg::RSV_W] == 4'h0);
      case (o_dec.per_channel_control)
        tcmd_pkg::PCC_MESSAGE:
        begin
          o_dec.message = i_word[tcmd_pkg::MSG_LSB +: 8];
          o_dec.use_msg = 1'b1;
          o_dec.drive_en = 1'b1;
        end
        tcmd_pkg::PCC_BERT:
        begin
          o_dec.use_bert = 1'b1;
          o_dec.drive_en = 1'b1;
        end
        // tristate and reserved leave the channel undriven
        default: o_dec.drive_en = 1'b0;
      endcase
      // conversion only meaningful for message output
      o_dec.conv_en = i_word[tcmd_pkg::CONV_BIT] & o_dec.use_msg;
    end
  end
endmodule

// ===== rtl/tcmd_law_xlate.sv
`timescale 1ns/10ps
// byte translation between the two coding laws
module tcmd_law_xlate (
  // control
  input wire logic i_conv_en,
  input wire tcmd_pkg::tcmd_law_t i_law,
  // data
  input wire logic [7:0] i_byte,
  output logic [7:0] o_byte
);
  // ----------------------------------------
  // translation
  // ----------------------------------------
  // simplified law swap: even-bit inversion only, sign bit left alone; a full
  // companding table would replace this without changing the port
  always_comb
  begin
    if (i_conv_en && (i_law.input_law != i_law.output_law))
      o_byte = i_byte ^ 8'h55;
    else
      o_byte = i_byte; // equal laws pass unchanged
  end
endmodule

// ===== verification/tcmd_host_model.sv
`timescale 1ns/10ps
// host side of the parallel port, one access at a time
module tcmd_host_model (
  // clock
  input wire logic i_clock,
  // port toward the device
  output logic [13:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_cs,
  output logic o_we,
  output logic o_high_sel,
  input wire logic [15:0] i_rdata,
  input wire logic i_ack
);
  initial
  begin
    o_addr = 14'h0000;
    o_wdata = 16'h0000;
    o_cs = 1'b0;
    o_we = 1'b0;
    o_high_sel = 1'b0;
  end
  // bit 13 of the address picks memory or registers; q stays unknown without an ack
  task automatic access(input logic [13:0] a, input logic [15:0] d, input logic w, input logic h,
    output logic [15:0] q);
    int n;
    n = 0;
    q = 16'hxxxx;
    @(posedge i_clock);
    o_addr <= a;
    o_wdata <= d;
    o_we <= w;
    o_high_sel <= h;
    o_cs <= 1'b1;
    @(posedge i_clock);
    o_cs <= 1'b0;
    // qualifiers held until the ack is sampled
    while (n < 8)
    begin
      @(posedge i_clock);
      n++;
      if (i_ack === 1'b1)
      begin
        q = i_rdata;
        n = 99;
      end
    end
    // released address and data lines never keep the old value
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
endmodule

// ===== verification/tb_tcmd_top.sv
`timescale 1ns/10ps
module tb_tcmd_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic i_clock;
  logic i_rst;
  logic [13:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic cs;
  logic we;
  logic hsel;
  logic ack;
  logic [12:0] idx;
  logic [7:0] sw;
  logic [7:0] bert;
  logic [7:0] sdata;
  logic oe;
  logic vfault;
  tcmd_pkg::tcmd_decode_t dec;
  logic [15:0] q;
  logic [8:0] m;
  int miscompares;
  int n_compared;
  int cycles;
  tcmd_top uut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_cs(cs), .i_we(we),
    .i_high_sel(hsel), .o_rdata(rdata), .o_ack(ack), .i_out_index(idx), .i_switched_byte(sw),
    .i_bert_byte(bert), .o_dec(dec), .o_stream_data(sdata), .o_stream_oe(oe), .o_var_fault(vfault));
  tcmd_host_model host (.i_clock(i_clock), .o_addr(addr), .o_wdata(wdata), .o_cs(cs), .o_we(we),
    .o_high_sel(hsel), .i_rdata(rdata), .i_ack(ack));
  // ----------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  // last-resort limit; a hung access already gives up after 8 cycles
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      wrap_up;
    end
  end
  task wrap_up;
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [13:0] a, input logic [15:0] d, input logic h);
    host.access(a, d, 1'b1, h, q);
  endtask
  task rd(input logic [13:0] a, input logic [15:0] e);
    host.access(a, 16'h0000, 1'b0, 1'b0, q);
    check(q, e);
  endtask
  // index held; the entry has settled two edges later
  task look(input logic [12:0] i);
    @(posedge i_clock);
    idx <= i;
    @(posedge i_clock);
    @(posedge i_clock);
    #1;
  endtask
  // normal switching entry at index 5, checked field by field
  task norm(input logic c, input logic [4:0] ss, input logic [7:0] sc, input logic [7:0] e);
    wr(14'h2005, {c, 1'b0, ss, sc, 1'b0}, 1'b0);
    look(13'h0005);
    check({dec.special, dec.conv_en, dec.var_delay, dec.src_stream, dec.src_channel}, {1'b0, c, 1'b0, ss, sc});
    check({6'h00, dec.use_switch, oe, sdata}, {6'h00, 2'h3, e});
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    i_rst = 1'b1;
    idx = 13'h0000;
    sw = 8'ha6;
    bert = 8'h3c;
    miscompares = 0;
    n_compared = 0;
    cycles = 0;
    repeat (16) @(posedge i_clock);
    #1;
    check({rdata[14:0], ack}, 16'h0000);
    check({vfault, oe, 6'h00, sdata}, 16'h0000);
    @(posedge i_clock);
    i_rst <= 1'b0;
    // registers versus memory, unmapped register reads zero
    wr(14'h0000, 16'h0003, 1'b0);
    wr(14'h2000, 16'h1234, 1'b0);
    rd(14'h0000, 16'h0003);
    rd(14'h2000, 16'h1234);
    rd(14'h0005, 16'h0000);
    // laws differ, programmed before conversion is asked for
    wr(14'h2005, 16'h0002, 1'b1);
    norm(1'b0, 5'h15, 8'hc3, 8'ha6);
    norm(1'b1, 5'h0a, 8'h3c, 8'hf3);
    wr(14'h2005, 16'h0003, 1'b1);
    norm(1'b1, 5'h1f, 8'h00, 8'ha6);
    // channel limit at every rate at the boundary, and past it for all but 16.384 Mbps
    for (int r = 0; r < 4; r++)
    begin
      m = (9'h020 << r) - 9'h001;
      wr(14'h0000, {14'h0000, r[1:0]}, 1'b0);
      wr(14'h2006, {2'h0, 5'h02, m[7:0], 1'b0}, 1'b0);
      look(13'h0006);
      check({15'h0000, dec.addr_ok}, 16'h0001);
      if (r < 3)
      begin
        wr(14'h2006, {2'h0, 5'h02, m[7:0] + 8'h01, 1'b0}, 1'b0);
        look(13'h0006);
        check({15'h0000, dec.addr_ok}, 16'h0000);
      end
    end
    // every control code, message sent without conversion though laws differ
    wr(14'h2007, 16'h0002, 1'b1);
    for (int p = 0; p < 4; p++)
    begin
      wr(14'h2007, {5'h00, 8'h5a + p[7:0], p[1:0], 1'b1}, 1'b0);
      look(13'h0007);
      check({dec.special, dec.per_channel_control, dec.use_msg, dec.use_bert, dec.use_switch, oe, dec.rsv_ok},
        {1'b1, p[1:0], p == 1, p == 2, 1'b0, p == 1 || p == 2, 1'b1});
      if (p == 1) check({8'h00, sdata}, {8'h00, 8'h5b});
      if (p == 2) check({8'h00, sdata}, {8'h00, 8'h3c});
    end
    wr(14'h2007, {5'h10, 8'h81, 2'h1, 1'b1}, 1'b0);
    look(13'h0007);
    check({dec.message, sdata}, {8'h81, 8'hd4});
    // nonzero reserved bits are flagged in status
    wr(14'h2008, {5'h09, 8'h00, 2'h1, 1'b1}, 1'b0);
    look(13'h0008);
    check({15'h0000, dec.rsv_ok}, 16'h0000);
    look(13'h0005);
    rd(14'h0002, 16'h0001);
    wr(14'h0002, 16'h0000, 1'b0);
    rd(14'h0002, 16'h0000);
    // variable delay before the global enable is a fault, data still passed
    wr(14'h0001, 16'h0000, 1'b0);
    wr(14'h2009, {2'h1, 5'h01, 8'h02, 1'b0}, 1'b0);
    look(13'h0009);
    check({13'h0000, vfault, dec.var_delay, dec.use_switch}, 16'h0007);
    check({8'h00, sdata}, 16'h00a6);
    rd(14'h0002, 16'h0002);
    wr(14'h0001, 16'h0001, 1'b0);
    wr(14'h0002, 16'h0000, 1'b0);
    rd(14'h0002, 16'h0000);
    check({15'h0000, vfault}, 16'h0000);
    wrap_up;
  end
endmodule
